//--- hdl/tcg_defs.svh
// Constants for the timer clock, gate and reload block.
// Assumes the includer provides the module context; definitions only.
`ifndef TCG_DEFS_SVH
`define TCG_DEFS_SVH
// --------------------------------
// Special function register addresses and pages
// --------------------------------
`define TCG_ADDR_TL1      8'h8b
`define TCG_ADDR_TH0      8'h8c
`define TCG_ADDR_TH1      8'h8d
`define TCG_ADDR_AUXCLK   8'ha3
`define TCG_ADDR_AUXPAGED 8'ha4
`define TCG_PAGE_PIN0     4'h0
`define TCG_PAGE_PIN1     4'h1
`define TCG_PAGE_GATE     4'h6
// --------------------------------
// Field positions
// --------------------------------
`define TCG_BIT_T1_PRESCALE 3
`define TCG_BIT_T0_PRESCALE 2
`define TCG_BIT_T1_CLKOUT   1
`define TCG_BIT_T0_CLKOUT   0
`define TCG_FLD_T0_ROUTE    7:6
`define TCG_BIT_T0_EXTRA    0
`define TCG_FLD_T1_ROUTE    5:4
`define TCG_BIT_T1_GATE1    5
`define TCG_BIT_T0_GATE1    4
// --------------------------------
// Reset values and counts
// --------------------------------
`define TCG_RESET_BYTE  8'h00
`define TCG_RESET_WORD  16'h0000
`define TCG_T2_TOP      16'hffff
`define TCG_DIV12_LAST  4'hb
`define TCG_DIV4_LAST   2'h3
`endif

//--- hdl/tcg_pkg.sv
// Types for the timer clock, gate and reload block.
// Assumes nothing of its surroundings.
package tcg_pkg;
  // Timer 0 (and timer 2) count source {extra, prescale, counter}
  typedef enum logic [2:0] {
    TCG_SRC_DIV12  = 3'b000,
    TCG_SRC_PIN    = 3'b001,
    TCG_SRC_SYS    = 3'b010,
    TCG_SRC_LSOSC  = 3'b011,
    TCG_SRC_DIV48  = 3'b100,
    TCG_SRC_WDT    = 3'b101,
    TCG_SRC_DIV192 = 3'b110,
    TCG_SRC_T1OVF  = 3'b111
  } tcg_src8_e;
  // Timer 1 count source {prescale, counter}
  typedef enum logic [1:0] {
    TCG_T1_DIV12 = 2'b00,
    TCG_T1_PIN   = 2'b01,
    TCG_T1_SYS   = 2'b10,
    TCG_T1_DIV48 = 2'b11
  } tcg_src4_e;
  // Timer 0 pin route
  typedef enum logic [1:0] {
    TCG_T0_P34 = 2'b00,
    TCG_T0_P44 = 2'b01,
    TCG_T0_P22 = 2'b10,
    TCG_T0_P26 = 2'b11
  } tcg_t0pin_e;
  // Timer 1 pin route, code 10 reserved
  typedef enum logic [1:0] {
    TCG_T1_P35  = 2'b00,
    TCG_T1_P45  = 2'b01,
    TCG_T1_RSVD = 2'b10,
    TCG_T1_P26  = 2'b11
  } tcg_t1pin_e;
  // Timer 2 reload modes
  typedef enum logic {
    TCG_T2_AR     = 1'b0,
    TCG_T2_AR_EXT = 1'b1
  } tcg_t2mode_e;
endpackage : tcg_pkg

//--- hdl/tcg_edge_sync.sv
// Two-stage synchroniser with rise and fall pulses.
// Assumes the input is asynchronous to clk and slower than clk/2.
`timescale 1ns/100ps
module tcg_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level
  input  wire logic asyncIn,
  // Synchronised results
  output logic      levelOut,
  output logic      risePulse,
  output logic      fallPulse
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // Stage 1 is read only by stage 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Edges from successive synchronised samples
  assign levelOut  = stage2_r;
  assign risePulse = stage2_r & ~stage3_r;
  assign fallPulse = ~stage2_r & stage3_r;
endmodule : tcg_edge_sync

//--- hdl/tcg_timer_clock_gate.sv
// Timer 0/1 clock, gate and pin selection; timer 2 reload modes 0 and 1.
// Assumes a CPU-side SFR port on clk; timer 0/1 mode logic lives outside.
`timescale 1ns/100ps
`include "tcg_defs.svh"
module tcg_timer_clock_gate (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // SFR port
  input  wire logic [3:0] sfrPage,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // Same-domain event and gate sources
  input  wire logic       watchdogPrescalerOut,
  input  wire logic       tmr1OverflowEvent,
  input  wire logic       tmr0OverflowEvent,
  input  wire logic       externalInterruptZero,
  input  wire logic       externalInterruptOne,
  input  wire logic       keypadInterrupt,
  input  wire logic       serial0TxFlag,
  // Asynchronous oscillator
  input  wire logic       lowSpeedInternalOsc,
  // Port pins
  input  wire logic       p34In,
  input  wire logic       p44In,
  input  wire logic       p22In,
  input  wire logic       p26In,
  input  wire logic       p35In,
  input  wire logic       p45In,
  output logic      [5:0] pinOut,
  output logic      [5:0] pinOe,
  // Timer 0/1 handoff to mode logic
  output logic            tmr0CountTick,
  output logic            tmr1CountTick,
  output logic            tmr0GateOpen,
  output logic            tmr1GateOpen,
  output logic      [7:0] tmr0CountHigh,
  output logic      [7:0] tmr1CountLow,
  output logic      [7:0] tmr1CountHigh,
  // Timer 2 control
  input  wire logic       tmr2Run,
  input  wire logic       tmr2ModeSel,
  input  wire logic [2:0] tmr2ClkSel,
  input  wire logic [2:0] tmr2ExtSel,
  input  wire logic [7:0] tmr2ExtSources,
  input  wire logic       tmr2CountPin,
  input  wire logic       tmr2FallingEdgeEnable,
  input  wire logic       tmr2RisingEdgeEnable,
  input  wire logic       tmr2OverflowIrqIgnore,
  input  wire logic       tmr2IrqEnable,
  input  wire logic [7:0] tmr2ReloadLow,
  input  wire logic [7:0] tmr2ReloadHigh,
  input  wire logic       tmr2OverflowClear,
  input  wire logic       tmr2ExternalClear,
  // Timer 2 status
  output logic      [7:0] tmr2CountLow,
  output logic      [7:0] tmr2CountHigh,
  output logic            tmr2OverflowFlag,
  output logic            tmr2ExternalFlag,
  output logic            tmr2OverflowEvent,
  output logic            tmr2IrqRequest
);
  // --------------------------------
  // Register file
  // --------------------------------
  logic [7:0]  th0_r, tl1_r, th1_r;
  logic [3:0]  auxClk_r;
  logic [1:0]  t0Route_r, t1Route_r;
  logic        t0Extra_r, t1Gate1_r, t0Gate1_r;
  logic        selPaged;
  assign selPaged = (sfrAddr == `TCG_ADDR_AUXPAGED);
  // Writes; paged address decoded by SFR page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      th0_r     <= `TCG_RESET_BYTE;
      tl1_r     <= `TCG_RESET_BYTE;
      th1_r     <= `TCG_RESET_BYTE;
      auxClk_r  <= 4'h0;
      t0Route_r <= 2'b00;
      t1Route_r <= 2'b00;
      t0Extra_r <= 1'b0;
      t1Gate1_r <= 1'b0;
      t0Gate1_r <= 1'b0;
    end else if (sfrWrite) begin
      if (sfrAddr == `TCG_ADDR_TH0) th0_r <= sfrWdata;
      if (sfrAddr == `TCG_ADDR_TL1) tl1_r <= sfrWdata;
      if (sfrAddr == `TCG_ADDR_TH1) th1_r <= sfrWdata;
      if (sfrAddr == `TCG_ADDR_AUXCLK) auxClk_r <= sfrWdata[3:0];
      if (selPaged && sfrPage == `TCG_PAGE_PIN0) begin
        t0Route_r <= sfrWdata[`TCG_FLD_T0_ROUTE];
        t0Extra_r <= sfrWdata[`TCG_BIT_T0_EXTRA];
      end
      if (selPaged && sfrPage == `TCG_PAGE_PIN1) t1Route_r <= sfrWdata[`TCG_FLD_T1_ROUTE];
      if (selPaged && sfrPage == `TCG_PAGE_GATE) begin
        t1Gate1_r <= sfrWdata[`TCG_BIT_T1_GATE1];
        t0Gate1_r <= sfrWdata[`TCG_BIT_T0_GATE1];
      end
    end
  end
  // Registered read data; bits owned by other blocks read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdata <= `TCG_RESET_BYTE;
    end else if (sfrRead) begin
      sfrRdata <= `TCG_RESET_BYTE;
      if (sfrAddr == `TCG_ADDR_TH0) sfrRdata <= th0_r;
      if (sfrAddr == `TCG_ADDR_TL1) sfrRdata <= tl1_r;
      if (sfrAddr == `TCG_ADDR_TH1) sfrRdata <= th1_r;
      if (sfrAddr == `TCG_ADDR_AUXCLK) sfrRdata <= {4'h0, auxClk_r};
      if (selPaged && sfrPage == `TCG_PAGE_PIN0) sfrRdata <= {t0Route_r, 5'b0_0000, t0Extra_r};
      if (selPaged && sfrPage == `TCG_PAGE_PIN1) sfrRdata <= {2'b00, t1Route_r, 4'h0};
      if (selPaged && sfrPage == `TCG_PAGE_GATE) sfrRdata <= {2'b00, t1Gate1_r, t0Gate1_r, 4'h0};
    end
  end
  assign tmr0CountHigh = th0_r;
  assign tmr1CountLow  = tl1_r;
  assign tmr1CountHigh = th1_r;
  // --------------------------------
  // Prescaler: /12, /48, /192 share one chain
  // --------------------------------
  logic [3:0] div12_r;
  logic [1:0] div48_r, div192_r;
  logic       tick12, tick48, tick192;
  assign tick12  = (div12_r == `TCG_DIV12_LAST);
  assign tick48  = tick12 && (div48_r == `TCG_DIV4_LAST);
  assign tick192 = tick48 && (div192_r == `TCG_DIV4_LAST);
  // Chained dividers keep the three rates phase-aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div12_r  <= 4'h0;
      div48_r  <= 2'b00;
      div192_r <= 2'b00;
    end else begin
      div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
      if (tick12) div48_r <= div48_r + 2'b01;
      if (tick48) div192_r <= div192_r + 2'b01;
    end
  end
  // --------------------------------
  // Pin routing and synchronised count inputs
  // --------------------------------
  tcg_pkg::tcg_t0pin_e t0Pin;
  tcg_pkg::tcg_t1pin_e t1Pin;
  logic t0PinRaw, t1PinRaw, t0PinRise, t1PinRise, oscRise, t2PinRise;
  assign t0Pin = tcg_pkg::tcg_t0pin_e'(t0Route_r);
  assign t1Pin = tcg_pkg::tcg_t1pin_e'(t1Route_r);
  // Raw pin pick before the synchroniser
  always_comb begin
    unique case (t0Pin)
      tcg_pkg::TCG_T0_P34: t0PinRaw = p34In;
      tcg_pkg::TCG_T0_P44: t0PinRaw = p44In;
      tcg_pkg::TCG_T0_P22: t0PinRaw = p22In;
      tcg_pkg::TCG_T0_P26: t0PinRaw = p26In;
    endcase
    unique case (t1Pin)
      tcg_pkg::TCG_T1_P35:  t1PinRaw = p35In;
      tcg_pkg::TCG_T1_P45:  t1PinRaw = p45In;
      tcg_pkg::TCG_T1_RSVD: t1PinRaw = 1'b0;  // Reserved: no pin
      tcg_pkg::TCG_T1_P26:  t1PinRaw = p26In;
    endcase
  end
  // Edge capture needs the source below clk/2
  tcg_edge_sync uT0Pin (.clk(clk), .rst_n(rst_n), .asyncIn(t0PinRaw),
    .levelOut(), .risePulse(t0PinRise), .fallPulse());
  tcg_edge_sync uT1Pin (.clk(clk), .rst_n(rst_n), .asyncIn(t1PinRaw),
    .levelOut(), .risePulse(t1PinRise), .fallPulse());
  tcg_edge_sync uOsc (.clk(clk), .rst_n(rst_n), .asyncIn(lowSpeedInternalOsc),
    .levelOut(), .risePulse(oscRise), .fallPulse());
  tcg_edge_sync uT2Pin (.clk(clk), .rst_n(rst_n), .asyncIn(tmr2CountPin),
    .levelOut(), .risePulse(t2PinRise), .fallPulse());
  // --------------------------------
  // Count clock selection
  // --------------------------------
  tcg_pkg::tcg_src8_e t0Src, t2Src;
  tcg_pkg::tcg_src4_e t1Src;
  logic               t2Tick;
  logic               tmr0CounterSelect, tmr1CounterSelect;
  // Counter-select bits live in the mode register outside this block
  assign tmr0CounterSelect = 1'b0;
  assign tmr1CounterSelect = 1'b0;
  assign t0Src = tcg_pkg::tcg_src8_e'({t0Extra_r,
    auxClk_r[`TCG_BIT_T0_PRESCALE], tmr0CounterSelect});
  assign t1Src = tcg_pkg::tcg_src4_e'({auxClk_r[`TCG_BIT_T1_PRESCALE],
    tmr1CounterSelect});
  assign t2Src = tcg_pkg::tcg_src8_e'(tmr2ClkSel);
  // Eight-way source pick, shared by timer 0 and timer 2
  function automatic logic pick8(input tcg_pkg::tcg_src8_e src,
                                 input logic pinEdge);
    unique case (src)
      tcg_pkg::TCG_SRC_DIV12:  pick8 = tick12;
      tcg_pkg::TCG_SRC_PIN:    pick8 = pinEdge;
      tcg_pkg::TCG_SRC_SYS:    pick8 = 1'b1;
      tcg_pkg::TCG_SRC_LSOSC:  pick8 = oscRise;
      tcg_pkg::TCG_SRC_DIV48:  pick8 = tick48;
      tcg_pkg::TCG_SRC_WDT:    pick8 = watchdogPrescalerOut;
      tcg_pkg::TCG_SRC_DIV192: pick8 = tick192;
      tcg_pkg::TCG_SRC_T1OVF:  pick8 = tmr1OverflowEvent;
    endcase
  endfunction : pick8
  // Tick selection for all three timers
  always_comb begin
    tmr0CountTick = pick8(t0Src, t0PinRise);
    t2Tick        = tmr2Run & pick8(t2Src, t2PinRise);
    unique case (t1Src)
      tcg_pkg::TCG_T1_DIV12: tmr1CountTick = tick12;
      tcg_pkg::TCG_T1_PIN:   tmr1CountTick = t1PinRise;
      tcg_pkg::TCG_T1_SYS:   tmr1CountTick = 1'b1;
      tcg_pkg::TCG_T1_DIV48: tmr1CountTick = tick48;
    endcase
  end
  // --------------------------------
  // Gating source selection
  // --------------------------------
  logic tmr0GateBit, tmr1GateBit;
  assign tmr0GateBit = 1'b0;  // Gate bits arrive with the mode register
  assign tmr1GateBit = 1'b0;
  // Gate open means counting allowed
  always_comb begin
    unique case ({t1Gate1_r, tmr1GateBit})
      2'b00: tmr1GateOpen = 1'b1;
      2'b01: tmr1GateOpen = externalInterruptOne;
      2'b10: tmr1GateOpen = keypadInterrupt;
      2'b11: tmr1GateOpen = serial0TxFlag;
    endcase
    unique case ({t0Gate1_r, tmr0GateBit})
      2'b00: tmr0GateOpen = 1'b1;
      2'b01: tmr0GateOpen = externalInterruptZero;
      2'b10: tmr0GateOpen = tmr2OverflowFlag;
      2'b11: tmr0GateOpen = keypadInterrupt;
    endcase
  end
  // --------------------------------
  // Clock outputs and pin drive
  // --------------------------------
  logic t0Clk_r, t1Clk_r;
  logic t0OutEn, t1OutEn;
  assign t0OutEn = auxClk_r[`TCG_BIT_T0_CLKOUT];
  assign t1OutEn = auxClk_r[`TCG_BIT_T1_CLKOUT];
  // Half-rate toggle on each overflow gives 50% duty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0Clk_r <= 1'b0;
      t1Clk_r <= 1'b0;
    end else begin
      t0Clk_r <= t0OutEn & (t0Clk_r ^ tmr0OverflowEvent);
      t1Clk_r <= t1OutEn & (t1Clk_r ^ tmr1OverflowEvent);
    end
  end
  // Pins [0..5] = P3.4 P4.4 P2.2 P2.6 P3.5 P4.5; timer 0 wins P2.6
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 6'b00_0000;
      pinOe  <= 6'b00_0000;
    end else begin
      pinOe[0] <= t0OutEn && t0Pin == tcg_pkg::TCG_T0_P34;
      pinOe[1] <= t0OutEn && t0Pin == tcg_pkg::TCG_T0_P44;
      pinOe[2] <= t0OutEn && t0Pin == tcg_pkg::TCG_T0_P22;
      pinOe[3] <= (t0OutEn && t0Pin == tcg_pkg::TCG_T0_P26) ||
                  (t1OutEn && t1Pin == tcg_pkg::TCG_T1_P26);
      pinOe[4] <= t1OutEn && t1Pin == tcg_pkg::TCG_T1_P35;
      pinOe[5] <= t1OutEn && t1Pin == tcg_pkg::TCG_T1_P45;
      pinOut   <= {t1Clk_r, t1Clk_r,
                   (t0OutEn && t0Pin == tcg_pkg::TCG_T0_P26) ? t0Clk_r : t1Clk_r,
                   t0Clk_r, t0Clk_r, t0Clk_r};
    end
  end
  // --------------------------------
  // Timer 2 external input and counter
  // --------------------------------
  logic        extRise, extFall, extEdge;
  logic [15:0] t2Count_r;
  logic        t2Ovf;
  tcg_pkg::tcg_t2mode_e t2Mode;
  assign t2Mode = tcg_pkg::tcg_t2mode_e'(tmr2ModeSel);
  // Selected input, then synchronised before edge detection
  tcg_edge_sync uT2Ext (.clk(clk), .rst_n(rst_n),
    .asyncIn(tmr2ExtSources[tmr2ExtSel]),
    .levelOut(), .risePulse(extRise), .fallPulse(extFall));
  assign extEdge = (tmr2FallingEdgeEnable & extFall) |
                   (tmr2RisingEdgeEnable & extRise);
  assign t2Ovf   = t2Tick && (t2Count_r == `TCG_T2_TOP);
  // Count, reload on overflow or, in mode 1, on the enabled edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t2Count_r <= `TCG_RESET_WORD;
    end else begin
      unique case (t2Mode)
        tcg_pkg::TCG_T2_AR: begin
          if (t2Ovf) t2Count_r <= {tmr2ReloadHigh, tmr2ReloadLow};
          else if (t2Tick) t2Count_r <= t2Count_r + 16'h0001;
        end
        tcg_pkg::TCG_T2_AR_EXT: begin
          if (t2Ovf || extEdge) t2Count_r <= {tmr2ReloadHigh, tmr2ReloadLow};
          else if (t2Tick) t2Count_r <= t2Count_r + 16'h0001;
        end
      endcase
    end
  end
  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr2OverflowFlag  <= 1'b0;
      tmr2ExternalFlag  <= 1'b0;
      tmr2OverflowEvent <= 1'b0;
    end else begin
      tmr2OverflowFlag  <= t2Ovf | (tmr2OverflowFlag & ~tmr2OverflowClear);
      tmr2ExternalFlag  <= extEdge | (tmr2ExternalFlag & ~tmr2ExternalClear);
      tmr2OverflowEvent <= t2Ovf;
    end
  end
  // Ignore blocks only the overflow flag
  assign tmr2IrqRequest = tmr2IrqEnable &
    ((tmr2OverflowFlag & ~tmr2OverflowIrqIgnore) | tmr2ExternalFlag);
  assign tmr2CountLow  = t2Count_r[7:0];
  assign tmr2CountHigh = t2Count_r[15:8];
endmodule : tcg_timer_clock_gate

//--- bench/tcg_timer_clock_gate_chk.sv
// Concurrent checks on the timer 2 ports.
// Assumes one clock domain; bound onto every instance of the top module.
`timescale 1ns/100ps
module tcg_timer_clock_gate_chk (
  // Clock and reset
  input logic       clk,
  input logic       rst_n,
  // Timer 2 control
  input logic       tmr2Run,
  input logic       tmr2ModeSel,
  input logic [2:0] tmr2ClkSel,
  input logic [2:0] tmr2ExtSel,
  input logic [7:0] tmr2ExtSources,
  input logic       tmr2FallingEdgeEnable,
  input logic       tmr2RisingEdgeEnable,
  input logic       tmr2OverflowIrqIgnore,
  input logic       tmr2IrqEnable,
  input logic [7:0] tmr2ReloadLow,
  input logic [7:0] tmr2ReloadHigh,
  input logic       tmr2ExternalClear,
  // Timer 2 status
  input logic [7:0] tmr2CountLow,
  input logic [7:0] tmr2CountHigh,
  input logic       tmr2OverflowFlag,
  input logic       tmr2ExternalFlag,
  input logic       tmr2OverflowEvent,
  input logic       tmr2IrqRequest
);
  logic [15:0] cnt;
  logic        extIn;
  // Whole count word and the selected event input
  assign cnt   = {tmr2CountHigh, tmr2CountLow};
  assign extIn = tmr2ExtSources[tmr2ExtSel];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_irq_from_flags: assert property (
    tmr2IrqRequest == (tmr2IrqEnable && (tmr2ExternalFlag ||
    (tmr2OverflowFlag && !tmr2OverflowIrqIgnore)))) else $error("irq not from flags");
  a_wrap_reloads: assert property (
    tmr2Run && tmr2ClkSel == 3'h2 && cnt == 16'hffff |=> tmr2OverflowEvent && tmr2OverflowFlag
    && cnt == $past({tmr2ReloadHigh, tmr2ReloadLow})) else $error("no reload on overflow");
  a_event_cause: assert property (
    tmr2OverflowEvent |-> $past(cnt) == 16'hffff) else $error("overflow event without wrap");
  a_count_step: assert property (
    tmr2Run && tmr2ClkSel == 3'h2 && !tmr2ModeSel && cnt != 16'hffff
    |=> cnt == $past(cnt) + 16'h0001) else $error("count did not step");
  a_ext_sticky: assert property (
    tmr2ExternalFlag && !tmr2ExternalClear |=> tmr2ExternalFlag) else $error("flag dropped");
  a_edge_enable: assert property (
    $rose(tmr2ExternalFlag) |-> $past(tmr2FallingEdgeEnable) || $past(tmr2RisingEdgeEnable))
    else $error("flag set while edges disabled");
  a_edge_sets_flag: assert property (
    ($fell(extIn) && tmr2FallingEdgeEnable) || ($rose(extIn) && tmr2RisingEdgeEnable)
    |-> ##[1:4] tmr2ExternalFlag) else $error("edge missed");
  a_mode1_reload: assert property (
    $rose(tmr2ExternalFlag) && tmr2ModeSel |-> cnt == {tmr2ReloadHigh, tmr2ReloadLow})
    else $error("edge reload missing");
  a_mode0_no_load: assert property (
    $rose(tmr2ExternalFlag) && !tmr2ModeSel && !tmr2Run |-> $stable(cnt))
    else $error("mode 0 edge changed count");
  // Main scenarios reached
  c_overflow: cover property (tmr2OverflowEvent);
  c_edge_reload: cover property ($rose(tmr2ExternalFlag) && tmr2ModeSel);
  c_irq_ignored: cover property (tmr2IrqRequest && tmr2OverflowIrqIgnore);
endmodule : tcg_timer_clock_gate_chk

bind tcg_timer_clock_gate tcg_timer_clock_gate_chk u_chk (.*);

//--- bench/tb_timer_clock_gate_and_reload.sv
// Self-checking bench for the timer clock, gate and reload block.
// Assumes the design files and the bound checker are compiled first.
`timescale 1ns/100ps
`include "tcg_defs.svh"
module tb_timer_clock_gate_and_reload;
  logic       clk, rst_n, sfrWrite, sfrRead, watchdogPrescalerOut, tmr1OverflowEvent;
  logic       tmr0OverflowEvent, externalInterruptZero, externalInterruptOne, keypadInterrupt;
  logic       serial0TxFlag, lowSpeedInternalOsc, p34In, p44In, p22In, p26In, p35In, p45In;
  logic       tmr2Run, tmr2ModeSel, tmr2CountPin, tmr2FallingEdgeEnable, tmr2RisingEdgeEnable;
  logic       tmr2OverflowIrqIgnore, tmr2IrqEnable, tmr2OverflowClear, tmr2ExternalClear;
  logic       tmr0CountTick, tmr1CountTick, tmr0GateOpen, tmr1GateOpen;
  logic       tmr2OverflowFlag, tmr2ExternalFlag, tmr2OverflowEvent, tmr2IrqRequest;
  logic [2:0] tmr2ClkSel, tmr2ExtSel;
  logic [3:0] sfrPage;
  logic [5:0] pinOut, pinOe;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, tmr2ExtSources, tmr2ReloadLow, tmr2ReloadHigh;
  logic [7:0] tmr0CountHigh, tmr1CountLow, tmr1CountHigh, tmr2CountLow, tmr2CountHigh;
  int         failures, samplesChecked;

  tcg_timer_clock_gate dut (.*);

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Run needs about 1200 cycles; generous margin
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Trailing idle cycle keeps back-to-back strobes apart
  task automatic sfr_wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    {sfrPage, sfrAddr, sfrWdata, sfrWrite} = {pg, a, d, 1'h1};
    cyc(1);
    sfrWrite = 1'h0;
    cyc(1);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [3:0] pg, input logic [7:0] a, output logic [7:0] d);
    {sfrPage, sfrAddr, sfrRead} = {pg, a, 1'h1};
    cyc(1);
    sfrRead = 1'h0;
    cyc(1);
    d = sfrRdata;
  endtask : sfr_rd
  task automatic print_verdict();
    if (failures == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, owned bits and an unmapped page and address
  task automatic t_regs();
    logic [7:0] d;
    logic [3:0] pg [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h6, 4'h2};
    logic [7:0] ad [8] = '{`TCG_ADDR_TL1, `TCG_ADDR_TH0, `TCG_ADDR_TH1, `TCG_ADDR_AUXCLK,
      `TCG_ADDR_AUXPAGED, `TCG_ADDR_AUXPAGED, `TCG_ADDR_AUXPAGED, 8'h90};
    logic [7:0] ms [8] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'hc1, 8'h30, 8'h30, 8'h00};
    for (int i = 0; i < 8; i++) begin
      sfr_rd(pg[i], ad[i], d);
      check("register reset", d, 8'h00);
      sfr_wr(pg[i], ad[i], 8'hff);
      sfr_rd(pg[i], ad[i], d);
      check("register mask", d, ms[i]);
      sfr_wr(pg[i], ad[i], 8'h00);
    end
  endtask : t_regs
  // Divided and undivided count clocks over a 192-cycle window
  task automatic t_ticks();
    int n0;
    int n1;
    logic [2:0] c [4] = '{3'h0, 3'h2, 3'h4, 3'h6};
    logic [15:0] e [4] = '{16'h0010, 16'h00c0, 16'h0004, 16'h0001};
    for (int i = 0; i < 4; i++) begin
      sfr_wr(4'h0, `TCG_ADDR_AUXPAGED, {7'h00, c[i][2]});
      sfr_wr(4'h0, `TCG_ADDR_AUXCLK, {4'h0, c[i][1], c[i][1], 2'h0});
      n0 = 0;
      n1 = 0;
      repeat (192) begin
        cyc(1);
        n0 += tmr0CountTick;
        n1 += tmr1CountTick;
      end
      check("timer 0 ticks", 16'(n0), e[i]);
      check("timer 1 ticks", 16'(n1), c[i][1] ? 16'h00c0 : 16'h0010);
    end
    sfr_wr(4'h0, `TCG_ADDR_AUXPAGED, 8'h00);
    sfr_wr(4'h0, `TCG_ADDR_AUXCLK, 8'h00);
  endtask : t_ticks
  // Gate sources: none, keypad for timer 1, overflow flag for timer 0
  task automatic t_gate();
    check("timer 1 ungated", tmr1GateOpen, 1'h1);
    check("timer 0 ungated", tmr0GateOpen, 1'h1);
    sfr_wr(4'h6, `TCG_ADDR_AUXPAGED, 8'h30);
    check("timer 1 keypad low", tmr1GateOpen, 1'h0);
    check("timer 0 flag low", tmr0GateOpen, 1'h0);
    keypadInterrupt = 1'h1;
    cyc(1);
    check("timer 1 keypad high", tmr1GateOpen, 1'h1);
    sfr_wr(4'h6, `TCG_ADDR_AUXPAGED, 8'h00);
  endtask : t_gate
  // Clock-out on routes P3.4, P2.6, P3.5 and P4.5, reserved route silent, disable releases pin
  task automatic t_clkout();
    logic [5:0] p;
    logic [3:0] pg [5] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1};
    logic [7:0] rt [5] = '{8'h00, 8'hc0, 8'h00, 8'h10, 8'h20};
    logic [5:0] mk [5] = '{6'h01, 6'h08, 6'h10, 6'h20, 6'h00};
    {p34In, p44In, p22In, p26In, p35In, p45In} = 6'h2a;
    for (int i = 0; i < 5; i++) begin
      sfr_wr(pg[i], `TCG_ADDR_AUXPAGED, rt[i]);
      sfr_wr(4'h0, `TCG_ADDR_AUXCLK, (i < 2) ? 8'h01 : 8'h02);
      cyc(1);
      p = pinOut;
      tmr0OverflowEvent = (i < 2);
      tmr1OverflowEvent = (i > 1);
      cyc(1);
      {tmr0OverflowEvent, tmr1OverflowEvent} = 2'h0;
      cyc(2);
      check("clock out drive", pinOe, mk[i]);
      check("clock out toggle", (pinOut ^ p) & pinOe, mk[i]);
      sfr_wr(4'h0, `TCG_ADDR_AUXCLK, 8'h00);
      cyc(1);
      check("clock out off", pinOe, 6'h00);
      sfr_wr(pg[i], `TCG_ADDR_AUXPAGED, 8'h00);
    end
  endtask : t_clkout
  // Timer 2 sources; async inputs held 4 cycles per level
  task automatic t_t2_src();
    logic [15:0] c;
    for (int s = 0; s < 4; s++) begin
      tmr2ClkSel = 3'(2 * s + 1);
      tmr2Run = 1'h1;
      c = {tmr2CountHigh, tmr2CountLow};
      repeat (3) begin
        {tmr2CountPin, lowSpeedInternalOsc, watchdogPrescalerOut, tmr1OverflowEvent} = 4'(8 >> s);
        cyc((s < 2) ? 4 : 1);
        {tmr2CountPin, lowSpeedInternalOsc, watchdogPrescalerOut, tmr1OverflowEvent} = 4'h0;
        cyc(4);
      end
      tmr2Run = 1'h0;
      check("timer 2 source count", {tmr2CountHigh, tmr2CountLow}, c + 16'h0003);
    end
  endtask : t_t2_src
  task automatic clr_ext();
    tmr2ExternalClear = 1'h1;
    cyc(1);
    tmr2ExternalClear = 1'h0;
  endtask : clr_ext
  // Edge flags per input, reloads, overflow, interrupt and ignore
  task automatic t_t2_ext();
    int n;
    tmr2FallingEdgeEnable = 1'h1;
    for (int s = 0; s < 8; s++) begin
      tmr2ExtSel = 3'(s);
      tmr2ExtSources = 8'hff ^ (8'h01 << ((s + 1) % 8));
      cyc(5);
      check("unselected input", tmr2ExternalFlag, 1'h0);
      tmr2ExtSources = 8'hff ^ (8'h01 << s);
      cyc(5);
      check("falling edge flag", tmr2ExternalFlag, 1'h1);
      clr_ext();
      tmr2ExtSources = 8'hff;
      cyc(5);
      check("rise ignored", tmr2ExternalFlag, 1'h0);
    end
    {tmr2FallingEdgeEnable, tmr2RisingEdgeEnable, tmr2ExtSel} = 5'h0b;
    tmr2ExtSources = 8'hf7;
    cyc(5);
    check("fall ignored", tmr2ExternalFlag, 1'h0);
    tmr2ExtSources = 8'hff;
    cyc(5);
    check("rising edge flag", tmr2ExternalFlag, 1'h1);
    clr_ext();
    {tmr2FallingEdgeEnable, tmr2RisingEdgeEnable, tmr2ModeSel} = 3'h5;
    {tmr2ReloadHigh, tmr2ReloadLow} = 16'hfff0;
    tmr2ExtSources = 8'hf7;
    cyc(5);
    check("edge reload", {tmr2CountHigh, tmr2CountLow}, 16'hfff0);
    check("edge reload flag", tmr2ExternalFlag, 1'h1);
    clr_ext();
    {tmr2ModeSel, tmr2ClkSel, tmr2Run} = 5'h05;
    for (n = 0; n < 40 && tmr2OverflowEvent !== 1'h1; n++) cyc(1);
    check("overflow event", tmr2OverflowEvent, 1'h1);
    check("overflow reload", {tmr2CountHigh, tmr2CountLow}, 16'hfff0);
    check("overflow flag", tmr2OverflowFlag, 1'h1);
    tmr2Run = 1'h0;
    cyc(1);
    check("event one cycle", tmr2OverflowEvent, 1'h0);
    {tmr2IrqEnable, tmr2OverflowIrqIgnore} = 2'h3;
    cyc(1);
    check("overflow irq ignored", tmr2IrqRequest, 1'h0);
    tmr2OverflowIrqIgnore = 1'h0;
    cyc(1);
    check("overflow irq", tmr2IrqRequest, 1'h1);
    sfr_wr(4'h6, `TCG_ADDR_AUXPAGED, 8'h10);
    check("timer 0 flag gate", tmr0GateOpen, 1'h1);
    tmr2OverflowClear = 1'h1;
    cyc(1);
    tmr2OverflowClear = 1'h0;
    check("flags cleared irq", tmr2IrqRequest, 1'h0);
  endtask : t_t2_ext

  // Reset for two cycles, then the scenarios in turn
  initial begin
    {sfrWrite, sfrRead, watchdogPrescalerOut, tmr1OverflowEvent, tmr0OverflowEvent} = 5'h00;
    {externalInterruptZero, externalInterruptOne, keypadInterrupt, serial0TxFlag} = 4'h0;
    {lowSpeedInternalOsc, p34In, p44In, p22In, p26In, p35In, p45In, tmr2CountPin} = 8'h00;
    {tmr2Run, tmr2ModeSel, tmr2FallingEdgeEnable, tmr2RisingEdgeEnable} = 4'h0;
    {tmr2OverflowIrqIgnore, tmr2IrqEnable, tmr2OverflowClear, tmr2ExternalClear} = 4'h0;
    {tmr2ClkSel, tmr2ExtSel, sfrPage, sfrAddr, sfrWdata} = 26'h000_0000;
    {tmr2ReloadLow, tmr2ReloadHigh, tmr2ExtSources} = 24'h00_00ff;
    {failures, samplesChecked} = 64'h0;
    rst_n = 1'h0;
    cyc(2);
    rst_n = 1'h1;
    cyc(1);
    t_regs();
    t_ticks();
    t_gate();
    t_clkout();
    t_t2_src();
    t_t2_ext();
    print_verdict();
  end
endmodule : tb_timer_clock_gate_and_reload
